// ===== hw/vrs_pkg.sv
package vrs_pkg;
   // command codes
   localparam logic [7:0] CMD_OPERATION   = 8'h01;
   localparam logic [7:0] CMD_ON_OFF_CFG  = 8'h02;
   localparam logic [7:0] CMD_VOUT_CMD    = 8'h21;
   localparam logic [7:0] CMD_VOUT_MAX    = 8'h24;
   localparam logic [7:0] CMD_VOUT_MIN    = 8'h28;
   localparam logic [7:0] CMD_SCALE_LOOP  = 8'h29;
   localparam logic [7:0] CMD_INPUT_TURNON_THRESHOLD      = 8'h35;
   localparam logic [7:0] CMD_INPUT_TURNOFF_THRESHOLD     = 8'h36;
   localparam logic [7:0] CMD_TON_DELAY   = 8'h60;
   localparam logic [7:0] CMD_TOFF_DELAY  = 8'h64;
   localparam logic [7:0] CMD_READ_VOUT   = 8'h8b;
   localparam logic [7:0] CMD_VREF_TRIM   = 8'hd4;
   localparam logic [7:0] CMD_MARGIN_HIGH = 8'hd5;
   localparam logic [7:0] CMD_MARGIN_LOW  = 8'hd6;
   // operation fields
   localparam int OP_ON_BIT      = 7;
   localparam int OP_MARGIN_LSB  = 4;
   localparam logic [1:0] MARGIN_NONE = 2'h0;
   localparam logic [1:0] MARGIN_LOW  = 2'h1;
   localparam logic [1:0] MARGIN_HIGH = 2'h2;
   // on_off_config fields
   localparam int CFG_USE_PIN_BIT = 3;
   localparam int CFG_USE_OP_BIT  = 2;
   // scale loop codes, units of 2^-9
   localparam logic [15:0] SCALE_1    = 16'h0200;
   localparam logic [15:0] SCALE_HALF = 16'h0100;
   localparam logic [15:0] SCALE_QTR  = 16'h0080;
   // vout_command valid ranges per scale
   localparam logic [15:0] VCMD_MIN_1 = 16'd179;
   localparam logic [15:0] VCMD_MAX_1 = 16'd845;
   localparam logic [15:0] VCMD_MIN_H = 16'd358;
   localparam logic [15:0] VCMD_MAX_H = 16'd1690;
   localparam logic [15:0] VCMD_MIN_Q = 16'd716;
   localparam logic [15:0] VCMD_MAX_Q = 16'd2816;
   // reference dac span, 2^-9 v steps
   localparam logic signed [13:0] DAC_MIN = 14'sd179;
   localparam logic signed [13:0] DAC_MAX = 14'sd845;
   // offsets, signed counts
   localparam logic signed [15:0] TRIM_MIN   = -16'sd64;
   localparam logic signed [15:0] TRIM_MAX   = 16'sd63;
   localparam logic signed [15:0] MARGIN_MIN = -16'sd64;
   localparam logic signed [15:0] MARGIN_MAX = 16'sd31;
   // input thresholds, units of 0.25 v
   localparam logic [15:0] INPUT_TURNOFF_THRESHOLD_LOWEST = 16'd16;
   localparam logic [15:0] INPUT_TURNON_THRESHOLD_HIGHEST = 16'd31;
   // reset values
   localparam logic [15:0] RST_VOUT_CMD  = 16'd512;
   localparam logic [15:0] RST_VOUT_MAX  = 16'd2816;
   localparam logic [15:0] RST_VOUT_MIN  = 16'd0;
   localparam logic [15:0] RST_INPUT_TURNON_THRESHOLD    = 16'd18;
   localparam logic [15:0] RST_INPUT_TURNOFF_THRESHOLD   = 16'd16;
   localparam logic [7:0]  RST_OPERATION = 8'h00;
   localparam logic [7:0]  RST_ON_OFF    = 8'h0c;
   localparam logic [15:0] RST_DELAY     = 16'd0;
   // timing
   localparam int DELAY_MAX_MS = 100;
   localparam int CLK_PERIOD_NS = 10;
   localparam int MS_NS = 1000000;
   localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
   // telemetry averaging
   localparam int AVG_LOG2 = 3;
endpackage

// ===== hw/vrs_top.sv
`timescale 1ns/1ps
`default_nettype none
module vrs_top #(
   parameter int MS_CYCLES = vrs_pkg::MS_CYCLES
) (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   // pmbus command port, already framed
   input  wire logic        cmd_wr,
   input  wire logic        cmd_rd,
   input  wire logic [7:0]  cmd_code,
   input  wire logic [15:0] cmd_wdata,
   output logic             rsp_valid,
   output logic             rsp_nack,
   output logic [15:0]      rsp_rdata,
   // converter side
   input  wire logic        control_pin,
   input  wire logic [15:0] vin_code,
   input  wire logic        sense_valid,
   input  wire logic [11:0] sense_amp_output,
   output logic             regulate_en,
   output logic [9:0]       error_amp_reference
);

   typedef enum logic [1:0] {ST_OFF, ST_ON_WAIT, ST_RUN, ST_OFF_WAIT} vrs_state_t;

   logic [7:0]         operation;
   logic [7:0]         on_off_cfg;
   logic [15:0]        vout_cmd;
   logic [15:0]        output_command_upper_limit;
   logic [15:0]        output_command_lower_limit;
   logic [15:0]        feedback_scale_ratio;
   logic [15:0]        input_turnon_threshold;
   logic [15:0]        input_turnoff_threshold;
   logic [15:0]        ton_delay;
   logic [15:0]        toff_delay;
   logic signed [15:0] vref_trim;
   logic signed [15:0] margin_up_offset;
   logic signed [15:0] margin_down_offset;
   logic [15:0]        read_vout;

   // control pin crosses from outside, two flops before use
   logic               pin_meta;
   logic               pin_sync;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pin_meta <= 1'b0;
         pin_sync <= 1'b0;
      end else begin
         pin_meta <= control_pin;
         pin_sync <= pin_meta;
      end
   end

   function automatic logic [15:0] clamp_u(input logic [15:0] v, input logic [15:0] lo,
                                           input logic [15:0] hi);
      if (v < lo)
         return lo;
      else if (v > hi)
         return hi;
      else
         return v;
   endfunction

   function automatic logic signed [15:0] clamp_s(input logic signed [15:0] v,
                                                  input logic signed [15:0] lo,
                                                  input logic signed [15:0] hi);
      if (v < lo)
         return lo;
      else if (v > hi)
         return hi;
      else
         return v;
   endfunction

   // valid command range for the present scale
   logic [15:0] range_lo;
   logic [15:0] range_hi;
   logic [1:0]  scale_shift;
   always_comb begin
      range_lo    = vrs_pkg::VCMD_MIN_1;
      range_hi    = vrs_pkg::VCMD_MAX_1;
      scale_shift = 2'd0;
      if (feedback_scale_ratio == vrs_pkg::SCALE_HALF) begin
         range_lo    = vrs_pkg::VCMD_MIN_H;
         range_hi    = vrs_pkg::VCMD_MAX_H;
         scale_shift = 2'd1;
      end else if (feedback_scale_ratio == vrs_pkg::SCALE_QTR) begin
         range_lo    = vrs_pkg::VCMD_MIN_Q;
         range_hi    = vrs_pkg::VCMD_MAX_Q;
         scale_shift = 2'd2;
      end
   end

   logic scale_ok;
   assign scale_ok = (cmd_wdata == vrs_pkg::SCALE_1) || (cmd_wdata == vrs_pkg::SCALE_HALF) ||
                     (cmd_wdata == vrs_pkg::SCALE_QTR);

   // limits first, then the scale range, so a stale limit cannot push past the table
   logic [15:0] next_vout_cmd;
   assign next_vout_cmd = clamp_u(clamp_u(cmd_wdata, output_command_lower_limit,
                                          output_command_upper_limit),
                                  range_lo, range_hi);

   logic mapped;
   always_comb begin
      case (cmd_code)
         vrs_pkg::CMD_OPERATION, vrs_pkg::CMD_ON_OFF_CFG, vrs_pkg::CMD_VOUT_CMD,
         vrs_pkg::CMD_VOUT_MAX, vrs_pkg::CMD_VOUT_MIN, vrs_pkg::CMD_SCALE_LOOP,
         vrs_pkg::CMD_INPUT_TURNON_THRESHOLD, vrs_pkg::CMD_INPUT_TURNOFF_THRESHOLD, vrs_pkg::CMD_TON_DELAY,
         vrs_pkg::CMD_TOFF_DELAY, vrs_pkg::CMD_READ_VOUT, vrs_pkg::CMD_VREF_TRIM,
         vrs_pkg::CMD_MARGIN_HIGH, vrs_pkg::CMD_MARGIN_LOW: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // an operation write pulses op_update for one cycle
   logic op_update;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         operation                  <= vrs_pkg::RST_OPERATION;
         on_off_cfg                 <= vrs_pkg::RST_ON_OFF;
         vout_cmd                   <= vrs_pkg::RST_VOUT_CMD;
         output_command_upper_limit <= vrs_pkg::RST_VOUT_MAX;
         output_command_lower_limit <= vrs_pkg::RST_VOUT_MIN;
         feedback_scale_ratio       <= vrs_pkg::SCALE_1;
         input_turnon_threshold     <= vrs_pkg::RST_INPUT_TURNON_THRESHOLD;
         input_turnoff_threshold    <= vrs_pkg::RST_INPUT_TURNOFF_THRESHOLD;
         ton_delay                  <= vrs_pkg::RST_DELAY;
         toff_delay                 <= vrs_pkg::RST_DELAY;
         vref_trim                  <= '0;
         margin_up_offset           <= '0;
         margin_down_offset         <= '0;
         op_update                  <= 1'b0;
      end else begin
         op_update <= 1'b0;
         if (cmd_wr) begin
            case (cmd_code)
               vrs_pkg::CMD_OPERATION: begin
                  operation <= cmd_wdata[7:0];
                  op_update <= 1'b1;
               end
               vrs_pkg::CMD_ON_OFF_CFG: on_off_cfg <= cmd_wdata[7:0];
               vrs_pkg::CMD_VOUT_CMD:   vout_cmd <= next_vout_cmd;
               vrs_pkg::CMD_VOUT_MAX:   output_command_upper_limit <= cmd_wdata;
               vrs_pkg::CMD_VOUT_MIN:   output_command_lower_limit <= cmd_wdata;
               vrs_pkg::CMD_SCALE_LOOP: begin
                  if (scale_ok)
                     feedback_scale_ratio <= cmd_wdata;
               end
               vrs_pkg::CMD_INPUT_TURNON_THRESHOLD: begin
                  input_turnon_threshold <= clamp_u(cmd_wdata, '0,
                                                    vrs_pkg::INPUT_TURNON_THRESHOLD_HIGHEST);
               end
               vrs_pkg::CMD_INPUT_TURNOFF_THRESHOLD: begin
                  input_turnoff_threshold <= clamp_u(cmd_wdata, vrs_pkg::INPUT_TURNOFF_THRESHOLD_LOWEST,
                                                     16'hffff);
               end
               vrs_pkg::CMD_TON_DELAY: begin
                  ton_delay <= clamp_u(cmd_wdata, '0,
                                       16'(vrs_pkg::DELAY_MAX_MS));
               end
               vrs_pkg::CMD_TOFF_DELAY: begin
                  toff_delay <= clamp_u(cmd_wdata, '0,
                                        16'(vrs_pkg::DELAY_MAX_MS));
               end
               vrs_pkg::CMD_VREF_TRIM: begin
                  vref_trim <= clamp_s(cmd_wdata, vrs_pkg::TRIM_MIN,
                                       vrs_pkg::TRIM_MAX);
               end
               vrs_pkg::CMD_MARGIN_HIGH: begin
                  margin_up_offset <= clamp_s(cmd_wdata, vrs_pkg::MARGIN_MIN,
                                              vrs_pkg::MARGIN_MAX);
               end
               vrs_pkg::CMD_MARGIN_LOW: begin
                  margin_down_offset <= clamp_s(cmd_wdata, vrs_pkg::MARGIN_MIN,
                                                vrs_pkg::MARGIN_MAX);
               end
               default: begin
               end
            endcase
         end
      end
   end

   // read answers one cycle after the strobe
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rsp_valid <= 1'b0;
         rsp_nack  <= 1'b0;
         rsp_rdata <= '0;
      end else begin
         rsp_valid <= cmd_rd || cmd_wr;
         rsp_nack  <= (cmd_rd || cmd_wr) && !mapped;
         if (cmd_rd) begin
            case (cmd_code)
               vrs_pkg::CMD_OPERATION:   rsp_rdata <= {8'h00, operation};
               vrs_pkg::CMD_ON_OFF_CFG:  rsp_rdata <= {8'h00, on_off_cfg};
               vrs_pkg::CMD_VOUT_CMD:    rsp_rdata <= vout_cmd;
               vrs_pkg::CMD_VOUT_MAX:    rsp_rdata <= output_command_upper_limit;
               vrs_pkg::CMD_VOUT_MIN:    rsp_rdata <= output_command_lower_limit;
               vrs_pkg::CMD_SCALE_LOOP:  rsp_rdata <= feedback_scale_ratio;
               vrs_pkg::CMD_INPUT_TURNON_THRESHOLD:      rsp_rdata <= input_turnon_threshold;
               vrs_pkg::CMD_INPUT_TURNOFF_THRESHOLD:     rsp_rdata <= input_turnoff_threshold;
               vrs_pkg::CMD_TON_DELAY:   rsp_rdata <= ton_delay;
               vrs_pkg::CMD_TOFF_DELAY:  rsp_rdata <= toff_delay;
               vrs_pkg::CMD_READ_VOUT:   rsp_rdata <= read_vout;
               vrs_pkg::CMD_VREF_TRIM:   rsp_rdata <= vref_trim;
               vrs_pkg::CMD_MARGIN_HIGH: rsp_rdata <= margin_up_offset;
               vrs_pkg::CMD_MARGIN_LOW:  rsp_rdata <= margin_down_offset;
               default:                  rsp_rdata <= '0;
            endcase
         end
      end
   end

   // input undervoltage lockout with hysteresis between the two thresholds
   logic vin_ok;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         vin_ok <= 1'b0;
      else if (!vin_ok && vin_code >= input_turnon_threshold)
         vin_ok <= 1'b1;
      else if (vin_ok && vin_code < input_turnoff_threshold)
         vin_ok <= 1'b0;
   end

   logic gate;
   assign gate = vin_ok && (!on_off_cfg[vrs_pkg::CFG_USE_PIN_BIT] || pin_sync) &&
                 (!on_off_cfg[vrs_pkg::CFG_USE_OP_BIT] ||
                  operation[vrs_pkg::OP_ON_BIT]);

   // millisecond enable; the divider free-runs so a delay may start mid-tick
   logic [31:0] ms_div;
   logic        ms_tick;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ms_div  <= '0;
         ms_tick <= 1'b0;
      end else if (ms_div == 32'(MS_CYCLES - 1)) begin
         ms_div  <= '0;
         ms_tick <= 1'b1;
      end else begin
         ms_div  <= ms_div + 32'd1;
         ms_tick <= 1'b0;
      end
   end

   vrs_state_t  state;
   logic [15:0] ms_left;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state       <= ST_OFF;
         ms_left     <= '0;
         regulate_en <= 1'b0;
      end else begin
         case (state)
            ST_OFF: begin
               regulate_en <= 1'b0;
               if (gate && ton_delay == '0) begin
                  state       <= ST_RUN;
                  regulate_en <= 1'b1;
               end else if (gate) begin
                  state   <= ST_ON_WAIT;
                  ms_left <= ton_delay;
               end
            end
            ST_ON_WAIT: begin
               if (!gate)
                  state <= ST_OFF;
               else if (ms_tick && ms_left == 16'd1) begin
                  state       <= ST_RUN;
                  regulate_en <= 1'b1;
               end else if (ms_tick)
                  ms_left <= ms_left - 16'd1;
            end
            ST_RUN: begin
               if (!gate && toff_delay == '0) begin
                  state       <= ST_OFF;
                  regulate_en <= 1'b0;
               end else if (!gate) begin
                  state   <= ST_OFF_WAIT;
                  ms_left <= toff_delay;
               end
            end
            ST_OFF_WAIT: begin
               if (gate)
                  state <= ST_RUN;
               else if (ms_tick && ms_left == 16'd1) begin
                  state       <= ST_OFF;
                  regulate_en <= 1'b0;
               end else if (ms_tick)
                  ms_left <= ms_left - 16'd1;
            end
            default: begin
               state       <= ST_OFF;
               regulate_en <= 1'b0;
            end
         endcase
      end
   end
   // op_update drives nothing; the gate reads the operation register itself
   logic unused_op_update;
   assign unused_op_update = op_update;

   // reference: scaled command plus margin plus trim, saturated to the dac span
   logic signed [13:0] base_ref;
   logic signed [13:0] margin_sel;
   logic signed [13:0] ref_sum;
   always_comb begin
      base_ref = $signed({2'b00, 12'(vout_cmd >> scale_shift)});
      case (operation[vrs_pkg::OP_MARGIN_LSB +: 2])
         vrs_pkg::MARGIN_HIGH: margin_sel = 14'(margin_up_offset);
         vrs_pkg::MARGIN_LOW:  margin_sel = 14'(margin_down_offset);
         default:              margin_sel = '0;
      endcase
      ref_sum = base_ref + margin_sel + 14'(vref_trim);
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         error_amp_reference <= 10'(vrs_pkg::DAC_MIN);
      else if (ref_sum < vrs_pkg::DAC_MIN)
         error_amp_reference <= 10'(vrs_pkg::DAC_MIN);
      else if (ref_sum > vrs_pkg::DAC_MAX)
         error_amp_reference <= 10'(vrs_pkg::DAC_MAX);
      else
         error_amp_reference <= 10'(ref_sum);
   end

   // telemetry: block average of 2^AVG_LOG2 samples; readback holds the last full block
   logic [2:0]  avg_cnt;
   logic [14:0] avg_acc;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         avg_cnt   <= '0;
         avg_acc   <= '0;
         read_vout <= '0;
      end else if (sense_valid) begin
         avg_cnt <= avg_cnt + 3'd1;
         if (avg_cnt == 3'd7) begin
            avg_acc   <= '0;
            read_vout <= 16'((avg_acc + 15'(sense_amp_output)) >> vrs_pkg::AVG_LOG2);
         end else
            avg_acc <= avg_acc + 15'(sense_amp_output);
      end
   end

endmodule
`default_nettype wire

// ===== verif/vrs_props.sv
`timescale 1ns/1ps
`default_nettype none
module vrs_props #(
   parameter int MS_CYCLES = 20
) (
   // clock and reset
   input wire logic        sys_clk,
   input wire logic        nrst,
   // command port
   input wire logic        cmd_wr,
   input wire logic        cmd_rd,
   input wire logic [7:0]  cmd_code,
   input wire logic [15:0] cmd_wdata,
   input wire logic        rsp_valid,
   input wire logic        rsp_nack,
   input wire logic [15:0] rsp_rdata,
   // converter side
   input wire logic        control_pin,
   input wire logic [15:0] vin_code,
   input wire logic        sense_valid,
   input wire logic [11:0] sense_amp_output,
   input wire logic        regulate_en,
   input wire logic [9:0]  error_amp_reference
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   property p_ref_span;
      error_amp_reference >= 10'h0b3 && error_amp_reference <= 10'h34d;
   endproperty
   a_ref_span: assert property (p_ref_span) else $error("reference outside dac span");
   // the reference only moves two edges after a register write
   property p_ref_cause;
      $changed(error_amp_reference) && $past(nrst, 2) |-> $past(cmd_wr, 2);
   endproperty
   a_ref_cause: assert property (p_ref_cause) else $error("reference moved without write");
   // input_turnoff_threshold cannot sit below 16, but a start needs only input_turnon_threshold, which can be written as low as 0
   property p_rise_vin;
      $rose(regulate_en) |-> $past(vin_code, 2) >= 16'h0010;
   endproperty
   a_rise_vin: assert property (p_rise_vin) else $error("start with input too low");
   property p_answer;
      cmd_wr || cmd_rd |=> rsp_valid;
   endproperty
   a_answer: assert property (p_answer) else $error("command not answered");
   property p_ans_cause;
      rsp_valid |-> $past(cmd_wr) || $past(cmd_rd);
   endproperty
   a_ans_cause: assert property (p_ans_cause) else $error("answer without command");
   property p_nack_map;
      rsp_nack |-> !($past(cmd_code) inside {8'h01, 8'h02, 8'h21, 8'h24, 8'h28, 8'h29, 8'h35,
                                              8'h36, 8'h60, 8'h64, 8'h8b, 8'hd4, 8'hd5, 8'hd6});
   endproperty
   a_nack_map: assert property (p_nack_map) else $error("mapped code refused");
   property p_nack_zero;
      rsp_nack && $past(cmd_rd) |-> rsp_rdata == 16'h0000;
   endproperty
   a_nack_zero: assert property (p_nack_zero) else $error("refused read not zero");
   property p_rdata_hold;
      !$past(cmd_rd) |-> $stable(rsp_rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
endmodule
bind vrs_top vrs_props #(.MS_CYCLES(MS_CYCLES)) i_vrs_props (.sys_clk(sys_clk), .nrst(nrst),
   .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
   .rsp_valid(rsp_valid), .rsp_nack(rsp_nack), .rsp_rdata(rsp_rdata),
   .control_pin(control_pin), .vin_code(vin_code), .sense_valid(sense_valid),
   .sense_amp_output(sense_amp_output), .regulate_en(regulate_en),
   .error_amp_reference(error_amp_reference));
`default_nettype wire

// ===== verif/vrs_host.sv
`timescale 1ns/1ps
`default_nettype none
module vrs_host (
   // clock
   input wire logic         sys_clk,
   // command port
   output logic             cmd_wr,
   output logic             cmd_rd,
   output logic [7:0]       cmd_code,
   output logic [15:0]      cmd_wdata,
   input wire logic         rsp_valid,
   input wire logic         rsp_nack,
   input wire logic [15:0]  rsp_rdata,
   // converter side
   output logic             control_pin,
   output logic [15:0]      vin_code,
   output logic             sense_valid,
   output logic [11:0]      sense_amp_output
);
   initial begin
      cmd_wr = 1'b0;
      cmd_rd = 1'b0;
      cmd_code = 8'h00;
      cmd_wdata = 16'h0000;
      control_pin = 1'b0;
      vin_code = 16'h0000;
      sense_valid = 1'b0;
      sense_amp_output = 12'h000;
   end
   // idle lines show inverted data so stale values never pass for fresh ones
   task automatic wr(input logic [7:0] code, input logic [15:0] data);
      @(negedge sys_clk);
      cmd_wr = 1'b1;
      cmd_code = code;
      cmd_wdata = data;
      @(negedge sys_clk);
      cmd_wr = 1'b0;
      cmd_code = ~code;
      cmd_wdata = ~data;
   endtask
   task automatic rd(input logic [7:0] code, output logic [15:0] data, output logic nack);
      @(negedge sys_clk);
      cmd_rd = 1'b1;
      cmd_code = code;
      @(negedge sys_clk);
      data = rsp_valid ? rsp_rdata : 16'hdead;
      nack = rsp_nack;
      cmd_rd = 1'b0;
      cmd_code = ~code;
   endtask
   task automatic lines(input logic pin, input logic [15:0] vin);
      @(negedge sys_clk);
      control_pin = pin;
      vin_code = vin;
   endtask
   task automatic sense(input logic [11:0] v);
      @(negedge sys_clk);
      sense_valid = 1'b1;
      sense_amp_output = v;
      @(negedge sys_clk);
      sense_valid = 1'b0;
      sense_amp_output = ~v;
   endtask
endmodule
`default_nettype wire

// ===== verif/vrs_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module vrs_top_tb;
   localparam int MSC = 20;
   logic        sys_clk;
   logic        nrst;
   logic        cmd_wr, cmd_rd, rsp_valid, rsp_nack, control_pin, sense_valid, regulate_en;
   logic [7:0]  cmd_code;
   logic [15:0] cmd_wdata, rsp_rdata, vin_code, rdat;
   logic [11:0] sense_amp_output;
   logic [9:0]  error_amp_reference;
   logic        nk;
   logic [15:0] smax [3] = '{16'd845, 16'd1690, 16'd2816};
   logic [15:0] smin [3] = '{16'd179, 16'd358, 16'd716};
   logic [15:0] scl  [3] = '{vrs_pkg::SCALE_1, vrs_pkg::SCALE_HALF, vrs_pkg::SCALE_QTR};
   logic [7:0]  ops  [4] = '{8'h20, 8'h10, 8'h00, 8'h30};
   logic [9:0]  oref [4] = '{10'd543, 10'd448, 10'd512, 10'd512};
   int          err_total, samples_checked, cycles;
   vrs_top #(.MS_CYCLES(MSC)) i_vrs_top (.sys_clk(sys_clk), .nrst(nrst), .cmd_wr(cmd_wr),
      .cmd_rd(cmd_rd), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
      .rsp_nack(rsp_nack), .rsp_rdata(rsp_rdata), .control_pin(control_pin),
      .vin_code(vin_code), .sense_valid(sense_valid), .sense_amp_output(sense_amp_output),
      .regulate_en(regulate_en), .error_amp_reference(error_amp_reference));
   vrs_host i_vrs_host (.sys_clk(sys_clk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
      .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
      .rsp_nack(rsp_nack), .rsp_rdata(rsp_rdata), .control_pin(control_pin),
      .vin_code(vin_code), .sense_valid(sense_valid), .sense_amp_output(sense_amp_output));
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         err_total++;
         $display("[FAIL] run length expected under 5000 seen 5000");
         complete_run();
      end
   end
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rchk(input logic [7:0] code, input logic [15:0] exp);
      i_vrs_host.rd(code, rdat, nk);
      chk($sformatf("register %h", code), exp, rdat);
   endtask
   task automatic wrchk(input logic [7:0] code, input logic [15:0] d, input logic [15:0] exp);
      i_vrs_host.wr(code, d);
      rchk(code, exp);
   endtask
   task automatic refchk(input logic [9:0] exp);
      repeat (2) @(negedge sys_clk);
      chk("reference", {6'h00, exp}, {6'h00, error_amp_reference});
   endtask
   // waits at most lim cycles for the converter to reach lvl
   task automatic regchk(input logic lvl, input int lim);
      for (int n = 0; n < lim && regulate_en !== lvl; n++) @(negedge sys_clk);
      chk("regulate", {15'h0000, lvl}, {15'h0000, regulate_en});
   endtask
   initial begin
      err_total = 0;
      samples_checked = 0;
      cycles = 0;
      nrst = 1'b0;
      repeat (10) @(negedge sys_clk);
      nrst = 1'b1;
      refchk(10'd512);
      rchk(vrs_pkg::CMD_INPUT_TURNON_THRESHOLD, vrs_pkg::RST_INPUT_TURNON_THRESHOLD);
      rchk(vrs_pkg::CMD_INPUT_TURNOFF_THRESHOLD, vrs_pkg::RST_INPUT_TURNOFF_THRESHOLD);
      rchk(vrs_pkg::CMD_SCALE_LOOP, vrs_pkg::SCALE_1);
      rchk(vrs_pkg::CMD_VOUT_MAX, vrs_pkg::RST_VOUT_MAX);
      rchk(vrs_pkg::CMD_VOUT_MIN, vrs_pkg::RST_VOUT_MIN);
      wrchk(vrs_pkg::CMD_INPUT_TURNON_THRESHOLD, 16'd40, 16'd31);
      wrchk(vrs_pkg::CMD_INPUT_TURNOFF_THRESHOLD, 16'd2, 16'd16);
      wrchk(vrs_pkg::CMD_INPUT_TURNON_THRESHOLD, 16'd20, 16'd20);
      wrchk(vrs_pkg::CMD_SCALE_LOOP, 16'h0300, vrs_pkg::SCALE_1);
      $display("test registers done");
      for (int i = 0; i < 3; i++) begin
         wrchk(vrs_pkg::CMD_SCALE_LOOP, scl[i], scl[i]);
         wrchk(vrs_pkg::CMD_VOUT_CMD, 16'd3000, smax[i]);
         refchk(10'(smax[i] >> i));
         wrchk(vrs_pkg::CMD_VOUT_CMD, 16'd0, smin[i]);
         refchk(10'd179);
      end
      i_vrs_host.wr(vrs_pkg::CMD_SCALE_LOOP, vrs_pkg::SCALE_1);
      i_vrs_host.wr(vrs_pkg::CMD_VOUT_MAX, 16'd600);
      wrchk(vrs_pkg::CMD_VOUT_CMD, 16'd700, 16'd600);
      i_vrs_host.wr(vrs_pkg::CMD_VOUT_MIN, 16'd300);
      wrchk(vrs_pkg::CMD_VOUT_CMD, 16'd250, 16'd300);
      i_vrs_host.wr(vrs_pkg::CMD_VOUT_MAX, 16'd2816);
      i_vrs_host.wr(vrs_pkg::CMD_VOUT_MIN, 16'd0);
      $display("test scaling done");
      wrchk(vrs_pkg::CMD_VREF_TRIM, 16'd100, 16'd63);
      wrchk(vrs_pkg::CMD_VREF_TRIM, 16'hff9c, 16'hffc0);
      i_vrs_host.wr(vrs_pkg::CMD_VOUT_CMD, 16'd512);
      i_vrs_host.wr(vrs_pkg::CMD_VREF_TRIM, 16'd5);
      refchk(10'd517);
      i_vrs_host.wr(vrs_pkg::CMD_VREF_TRIM, 16'd0);
      wrchk(vrs_pkg::CMD_MARGIN_HIGH, 16'd50, 16'd31);
      wrchk(vrs_pkg::CMD_MARGIN_LOW, 16'hffb0, 16'hffc0);
      for (int i = 0; i < 4; i++) begin
         i_vrs_host.wr(vrs_pkg::CMD_OPERATION, {8'h00, ops[i]});
         refchk(oref[i]);
      end
      i_vrs_host.wr(vrs_pkg::CMD_VOUT_CMD, 16'd845);
      i_vrs_host.wr(vrs_pkg::CMD_OPERATION, 16'h0020);
      refchk(10'd845);
      i_vrs_host.wr(vrs_pkg::CMD_VOUT_CMD, 16'd179);
      i_vrs_host.wr(vrs_pkg::CMD_OPERATION, 16'h0010);
      refchk(10'd179);
      $display("test reference done");
      for (int i = 0; i < 8; i++) i_vrs_host.sense(12'd100 + 12'(i));
      rchk(vrs_pkg::CMD_READ_VOUT, 16'd103);
      i_vrs_host.rd(8'h55, rdat, nk);
      chk("unmapped nack", 16'h0001, {15'h0000, nk});
      chk("unmapped data", 16'h0000, rdat);
      $display("test telemetry done");
      i_vrs_host.lines(1'b1, 16'd24);
      i_vrs_host.wr(vrs_pkg::CMD_TON_DELAY, 16'd2);
      i_vrs_host.wr(vrs_pkg::CMD_TOFF_DELAY, 16'd3);
      // wait past the programmed two tick on delay: pin and input alone must not start the converter
      repeat (45) @(negedge sys_clk);
      regchk(1'b0, 0);
      i_vrs_host.wr(vrs_pkg::CMD_OPERATION, 16'h0080);
      // a two tick delay cannot finish inside one tick period
      repeat (15) @(negedge sys_clk);
      regchk(1'b0, 0);
      regchk(1'b1, 40);
      i_vrs_host.lines(1'b0, 16'd24);
      repeat (30) @(negedge sys_clk);
      regchk(1'b1, 0);
      regchk(1'b0, 40);
      i_vrs_host.wr(vrs_pkg::CMD_TON_DELAY, 16'd0);
      i_vrs_host.wr(vrs_pkg::CMD_TOFF_DELAY, 16'd0);
      i_vrs_host.wr(vrs_pkg::CMD_ON_OFF_CFG, 16'h0000);
      regchk(1'b1, 6);
      // between the thresholds the previous state holds
      i_vrs_host.lines(1'b0, 16'd17);
      repeat (5) @(negedge sys_clk);
      regchk(1'b1, 0);
      i_vrs_host.lines(1'b0, 16'd15);
      regchk(1'b0, 6);
      i_vrs_host.lines(1'b0, 16'd19);
      repeat (5) @(negedge sys_clk);
      regchk(1'b0, 0);
      i_vrs_host.lines(1'b0, 16'd20);
      regchk(1'b1, 10);
      $display("test sequencing done");
      complete_run();
   end
endmodule
`default_nettype wire
